/* core/scsw_map.svh */
// Register map, key values and timing counts for the clock source switcher
`ifndef SCSW_MAP_SVH
`define SCSW_MAP_SVH
`define SCSW_OFF_OSCCTL 12'h000
`define SCSW_OFF_CFG 12'h004
`define SCSW_OFF_STAT 12'h008
`define SCSW_KEY_HI1 8'h78
`define SCSW_KEY_HI2 8'h9a
`define SCSW_KEY_LO1 8'h46
`define SCSW_KEY_LO2 8'h57
`define SCSW_BIT_REQ 0
`define SCSW_BIT_CF 3
`define SCSW_BIT_LOCK 5
`define SCSW_NEXT_SOURCE_FIELD_LSB 8
`define SCSW_CURRENT_SOURCE_FIELD_LSB 12
`define SCSW_SRC_FRC 3'h0
`define SCSW_SRC_FRCPLL 3'h1
`define SCSW_SRC_PRI 3'h2
`define SCSW_SRC_PRIPLL 3'h3
`define SCSW_SRC_SEC 3'h4
`define SCSW_SRC_LOW_POWER_RC_SOURCE 3'h5
`define SCSW_SRC_FRCDIV 3'h7
`define SCSW_OST_CYCLES 1024
`endif

/* core/scsw_pkg.sv */
// Types for the clock source switcher
package scsw_pkg;
    typedef logic [2:0] scsw_src_t;
    typedef enum logic [1:0] {SCSW_UL_IDLE, SCSW_UL_ONE, SCSW_UL_OPEN} scsw_unlock_t;
    typedef enum logic [1:0] {SCSW_IDLE, SCSW_START, SCSW_WAIT} scsw_state_t;
endpackage

/* core/scsw_switcher.sv */
// System clock source switcher with keyed control register on AXI4-Lite
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "scsw_map.svh"
module scsw_switcher #(
    parameter int OST_CYCLES = `SCSW_OST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] startupSourceConfig,
    input wire logic switchEnableConfigBit,
    input wire logic twoSpeedStartupEnable,
    input wire logic failSafeMonitorEnable,
    input wire logic watchdogEnable,
    input wire logic secondaryOscEnable,
    input wire logic pllLocked,
    input wire logic sourceRunning,
    input wire logic sleepEnter,
    input wire logic sleepWake,
    input wire logic clockFailEvent,
    output logic [2:0] selectedSource,
    output logic [7:0] sourcePowerOn,
    output logic pllEnable,
    output logic ostRunning
);
    import scsw_pkg::*;

    localparam int OW = $clog2(OST_CYCLES + 1);

    function automatic logic uses_pll(input scsw_src_t s);
        uses_pll = (s == `SCSW_SRC_FRCPLL) || (s == `SCSW_SRC_PRIPLL);
    endfunction

    function automatic logic is_crystal(input scsw_src_t s);
        is_crystal = (s == `SCSW_SRC_PRI) || (s == `SCSW_SRC_PRIPLL) || (s == `SCSW_SRC_SEC);
    endfunction

    // Power bit index for a source; PLL modes get their own bit, apart from their base oscillator
    function automatic logic [7:0] src_onehot(input scsw_src_t s);
        src_onehot = 8'h01 << s;
    endfunction

    scsw_src_t curSrc_reg;
    scsw_src_t nextSrc_reg;
    logic req_reg;
    logic lock_reg;
    logic cf_reg;
    scsw_state_t state_reg;
    scsw_unlock_t ulHi_reg;
    scsw_unlock_t ulLo_reg;
    logic [OW-1:0] ost_reg;
    logic twoSpeed_reg;
    logic [7:0] power_reg;
    logic pll_reg;

    // Write channel: address and data accepted independently, response after both
    logic awHeld_reg;
    logic wHeld_reg;
    logic [11:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic doWrite;
    logic swEnabled;

    assign swEnabled = !switchEnableConfigBit;
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 12'h000;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            s_axi_awready <= !awHeld_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_reg[11:2] == `SCSW_OFF_OSCCTL >> 2) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Each bus write to the control word is one instruction for key timing
    logic ctlWrite;
    logic hiLane;
    logic loLane;
    logic [7:0] hiByte;
    logic [7:0] loByte;
    logic hiAccept;
    logic loAccept;
    assign ctlWrite = doWrite && (awAddr_reg[11:2] == `SCSW_OFF_OSCCTL >> 2);
    assign hiLane = ctlWrite && wStrb_reg[1];
    assign loLane = ctlWrite && wStrb_reg[0];
    assign hiByte = wData_reg[15:8];
    assign loByte = wData_reg[7:0];
    assign hiAccept = hiLane && (ulHi_reg == SCSW_UL_OPEN);
    assign loAccept = loLane && (ulLo_reg == SCSW_UL_OPEN);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ulHi_reg <= SCSW_UL_IDLE;
        else if (ctlWrite)
        begin
            unique case (ulHi_reg)
                SCSW_UL_IDLE: ulHi_reg <= (hiLane && hiByte == `SCSW_KEY_HI1) ? SCSW_UL_ONE
                    : SCSW_UL_IDLE;
                SCSW_UL_ONE: ulHi_reg <= (hiLane && hiByte == `SCSW_KEY_HI2) ? SCSW_UL_OPEN
                    : SCSW_UL_IDLE;
                SCSW_UL_OPEN: ulHi_reg <= SCSW_UL_IDLE;
                default: ulHi_reg <= SCSW_UL_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ulLo_reg <= SCSW_UL_IDLE;
        else if (ctlWrite)
        begin
            unique case (ulLo_reg)
                SCSW_UL_IDLE: ulLo_reg <= (loLane && loByte == `SCSW_KEY_LO1) ? SCSW_UL_ONE
                    : SCSW_UL_IDLE;
                SCSW_UL_ONE: ulLo_reg <= (loLane && loByte == `SCSW_KEY_LO2) ? SCSW_UL_OPEN
                    : SCSW_UL_IDLE;
                SCSW_UL_OPEN: ulLo_reg <= SCSW_UL_IDLE;
                default: ulLo_reg <= SCSW_UL_IDLE;
            endcase
        end
    end

    // Strap capture one cycle after reset release
    logic [1:0] rstDone_reg;

    // Next-source field; writes still taken during two-speed start-up
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            nextSrc_reg <= `SCSW_SRC_FRCDIV;
        else if (hiAccept)
            nextSrc_reg <= hiByte[2:0];
        else if (rstDone_reg == 2'd1 && twoSpeedStartupEnable
            && startupSourceConfig != `SCSW_SRC_FRC)
            nextSrc_reg <= startupSourceConfig;
        else if (sleepWake && twoSpeedStartupEnable && curSrc_reg != `SCSW_SRC_FRC)
            nextSrc_reg <= curSrc_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rstDone_reg <= 2'd0;
        else if (rstDone_reg != 2'd2)
            rstDone_reg <= rstDone_reg + 2'd1;
    end

    logic reqWrite;
    logic reqValue;
    logic redundant;
    logic stable;
    logic autoStart;
    assign reqWrite = loAccept;
    assign reqValue = loByte[`SCSW_BIT_REQ];
    assign redundant = (nextSrc_reg == curSrc_reg);
    assign stable = sourceRunning && (ost_reg == '0) && (!uses_pll(nextSrc_reg) || pllLocked);
    // Two-speed start-up ignores the switch-enable strap
    assign autoStart = twoSpeed_reg && state_reg == SCSW_IDLE && rstDone_reg == 2'd2;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            twoSpeed_reg <= 1'b0;
        else if (rstDone_reg == 2'd1)
            twoSpeed_reg <= twoSpeedStartupEnable
                && startupSourceConfig != `SCSW_SRC_FRC;
        else if (sleepWake && twoSpeedStartupEnable && curSrc_reg != `SCSW_SRC_FRC)
            twoSpeed_reg <= 1'b1;
        else if (state_reg == SCSW_WAIT && stable && twoSpeed_reg)
            twoSpeed_reg <= 1'b0;
        else if (sleepEnter)
            twoSpeed_reg <= 1'b0;
    end

    // Switch sequencer; runs beside the core and never holds it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= SCSW_IDLE;
            req_reg <= 1'b0;
            curSrc_reg <= `SCSW_SRC_FRC;
            lock_reg <= 1'b0;
            cf_reg <= 1'b0;
            ost_reg <= '0;
            pll_reg <= 1'b0;
        end
        else
        begin
            lock_reg <= pllLocked && pll_reg;
            if (clockFailEvent)
                cf_reg <= 1'b1;
            if (rstDone_reg == 2'd1)
                curSrc_reg <= (swEnabled && twoSpeedStartupEnable) || twoSpeedStartupEnable
                    ? `SCSW_SRC_FRC : startupSourceConfig;
            else if (sleepWake && twoSpeedStartupEnable && curSrc_reg != `SCSW_SRC_FRC)
                curSrc_reg <= `SCSW_SRC_FRC;
            if (sleepEnter)
            begin
                state_reg <= SCSW_IDLE;
                req_reg <= 1'b0;
                ost_reg <= '0;
                pll_reg <= uses_pll(curSrc_reg);
            end
            else if (!swEnabled && !twoSpeed_reg)
            begin
                req_reg <= 1'b0;
                state_reg <= SCSW_IDLE;
            end
            else if (reqWrite && !reqValue)
            begin
                req_reg <= 1'b0;
                state_reg <= SCSW_IDLE;
                ost_reg <= '0;
                pll_reg <= uses_pll(curSrc_reg);
            end
            else if ((reqWrite && reqValue && swEnabled) || autoStart)
            begin
                // A fresh request restarts the sequence from scratch
                req_reg <= 1'b1;
                state_reg <= SCSW_START;
                ost_reg <= '0;
            end
            else
            begin
                unique case (state_reg)
                    SCSW_IDLE: ;
                    SCSW_START:
                    begin
                        if (redundant)
                        begin
                            req_reg <= 1'b0;
                            state_reg <= SCSW_IDLE;
                        end
                        else
                        begin
                            lock_reg <= 1'b0;
                            cf_reg <= clockFailEvent;
                            ost_reg <= is_crystal(nextSrc_reg) && !power_reg[nextSrc_reg]
                                ? OW'(OST_CYCLES) : '0;
                            pll_reg <= uses_pll(nextSrc_reg) || uses_pll(curSrc_reg);
                            state_reg <= SCSW_WAIT;
                        end
                    end
                    SCSW_WAIT:
                    begin
                        if (ost_reg != '0 && sourceRunning)
                            ost_reg <= ost_reg - OW'(1);
                        // No timeout: an absent source leaves the request pending
                        if (stable)
                        begin
                            curSrc_reg <= nextSrc_reg;
                            req_reg <= 1'b0;
                            pll_reg <= uses_pll(nextSrc_reg);
                            state_reg <= SCSW_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Source power: current and target on, retained ones kept, others off
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            power_reg <= src_onehot(`SCSW_SRC_FRC);
        else
        begin
            power_reg <= src_onehot(curSrc_reg)
                | (state_reg == SCSW_WAIT ? src_onehot(nextSrc_reg) : 8'h00)
                | ((watchdogEnable || failSafeMonitorEnable)
                    ? src_onehot(`SCSW_SRC_LOW_POWER_RC_SOURCE) : 8'h00)
                | (secondaryOscEnable ? src_onehot(`SCSW_SRC_SEC) : 8'h00)
                | (sleepWake && twoSpeedStartupEnable
                    ? src_onehot(`SCSW_SRC_FRC) : 8'h00);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            selectedSource <= `SCSW_SRC_FRC;
            sourcePowerOn <= src_onehot(`SCSW_SRC_FRC);
            pllEnable <= 1'b0;
            ostRunning <= 1'b0;
        end
        else
        begin
            selectedSource <= curSrc_reg;
            sourcePowerOn <= power_reg;
            pllEnable <= pll_reg;
            ostRunning <= ost_reg != '0;
        end
    end

    // Read channel: one-cycle answer after the address is taken
    logic [31:0] ctlWord;
    assign ctlWord = {16'h0000, 1'b0, curSrc_reg, 1'b0, nextSrc_reg, 2'b00, lock_reg, 1'b0,
        cf_reg, 2'b00, req_reg};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                unique case (s_axi_araddr[11:2])
                    `SCSW_OFF_OSCCTL >> 2: s_axi_rdata <= ctlWord;
                    `SCSW_OFF_CFG >> 2: s_axi_rdata <= {26'h0, swEnabled, twoSpeed_reg,
                        1'b0, startupSourceConfig};
                    `SCSW_OFF_STAT >> 2: s_axi_rdata <= {22'h0, ostRunning, pll_reg, power_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* sim/scsw_switcher_monitor.sv */
// Port-level checker for the clock source switcher
`timescale 1ns/10ps
module scsw_switcher_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pllLocked,
    input wire logic sourceRunning,
    input wire logic [2:0] selectedSource,
    input wire logic [7:0] sourcePowerOn,
    input wire logic pllEnable
);
    logic [2:0] upCount;
    logic settled;
    // Keeps source checks quiet while straps load after a reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            upCount <= 3'h0;
        else if (upCount != 3'h7)
            upCount <= upCount + 3'h1;
    end
    assign settled = upCount == 3'h7;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence readTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence writeTaken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence srcChange;
        settled && $changed(selectedSource);
    endsequence
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_answer: assert property (readTaken |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (writeTaken |-> ##[1:4] s_axi_bvalid)
        else $error("write answer missing");
    a_unmapped_read: assert property (readTaken ##0 s_axi_araddr >= 12'h00c |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    a_switch_stable: assert property (srcChange |-> $past(sourceRunning, 2))
        else $error("switched to a source that was not running");
    a_pll_lock: assert property (srcChange ##0 (selectedSource == 3'h1 || selectedSource == 3'h3)
        |-> $past(pllLocked, 2))
        else $error("switched to pll source without lock");
    a_pll_kept: assert property (srcChange ##0 (selectedSource == 3'h1 || selectedSource == 3'h3)
        |-> pllEnable && $past(pllEnable))
        else $error("pll not running at switch");
    a_new_powered: assert property (srcChange |-> sourcePowerOn[selectedSource])
        else $error("selected source not powered");
endmodule
bind scsw_switcher scsw_switcher_monitor mon_u (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pllLocked(pllLocked),
    .sourceRunning(sourceRunning), .selectedSource(selectedSource),
    .sourcePowerOn(sourcePowerOn), .pllEnable(pllEnable));

/* sim/scsw_switcher_bench.sv */
// Self-checking bench for the clock source switcher
`timescale 1ns/10ps
module scsw_switcher_bench;
    logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [2:0] startupSourceConfig, selectedSource;
    logic switchEnableConfigBit, twoSpeedStartupEnable, failSafeMonitorEnable, watchdogEnable;
    logic secondaryOscEnable, pllLocked, sourceRunning, sleepEnter, sleepWake, clockFailEvent;
    logic [7:0] sourcePowerOn;
    logic pllEnable, ostRunning;
    int n_fail, comparisons;
    scsw_switcher #(.OST_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .startupSourceConfig(startupSourceConfig), .switchEnableConfigBit(switchEnableConfigBit),
        .twoSpeedStartupEnable(twoSpeedStartupEnable),
        .failSafeMonitorEnable(failSafeMonitorEnable), .watchdogEnable(watchdogEnable),
        .secondaryOscEnable(secondaryOscEnable), .pllLocked(pllLocked),
        .sourceRunning(sourceRunning), .sleepEnter(sleepEnter), .sleepWake(sleepWake),
        .clockFailEvent(clockFailEvent), .selectedSource(selectedSource),
        .sourcePowerOn(sourcePowerOn), .pllEnable(pllEnable), .ostRunning(ostRunning));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rdw(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Key bytes go to both lanes; the strobe picks which byte is unlocked
    task keys(input logic [7:0] k1, input logic [7:0] k2, input logic [3:0] s);
        wr(12'h000, {16'h0, k1, k1}, s);
        wr(12'h000, {16'h0, k2, k2}, s);
    endtask
    task setNext(input logic [2:0] src);
        keys(8'h78, 8'h9a, 4'h2);
        wr(12'h000, {21'h0, src, 8'h0}, 4'h2);
    endtask
    task req(input logic b);
        keys(8'h46, 8'h57, 4'h1);
        wr(12'h000, {31'h0, b}, 4'h1);
    endtask
    task ctl(input logic r, input logic [2:0] nx, input logic [2:0] cur);
        rdw(12'h000);
        check({25'h0, rd[14:12], rd[10:8], rd[0]}, {25'h0, cur, nx, r});
    endtask
    // Polls until the switch lands; the watchdog ends a switch that never lands
    task waitCur(input logic [2:0] src);
        do
            rdw(12'h000);
        while (rd[14:12] !== src);
    endtask
    task scenReset;
        ctl(1'b0, 3'h7, 3'h0);
        check({24'h0, sourcePowerOn}, 32'h1);
        rdw(12'h010);
        check({30'h0, resp}, 32'h2);
        check(rd, 32'h0);
        wr(12'h010, 32'h0, 4'hf);
        check({30'h0, resp}, 32'h2);
    endtask
    task scenPrimary;
        sourceRunning <= 1'b0;
        setNext(3'h2);
        req(1'b1);
        repeat (10) @(posedge sys_clk);
        ctl(1'b1, 3'h2, 3'h0);
        check({31'h0, ostRunning}, 32'h1);
        sourceRunning <= 1'b1;
        waitCur(3'h2);
        ctl(1'b0, 3'h2, 3'h2);
        check({29'h0, selectedSource}, 32'h2);
        check({31'h0, sourcePowerOn[0]}, 32'h0);
    endtask
    task scenRedundant;
        sourceRunning <= 1'b0;
        req(1'b1);
        ctl(1'b0, 3'h2, 3'h2);
        sourceRunning <= 1'b1;
    endtask
    task scenKeys;
        keys(8'h78, 8'h11, 4'h2);
        wr(12'h000, {21'h0, 3'h4, 8'h0}, 4'h2);
        ctl(1'b0, 3'h2, 3'h2);
        wr(12'h000, 32'h1, 4'h1);
        ctl(1'b0, 3'h2, 3'h2);
        setNext(3'h4);
        wr(12'h000, {21'h0, 3'h5, 8'h0}, 4'h2);
        ctl(1'b0, 3'h4, 3'h2);
        switchEnableConfigBit <= 1'b1;
        req(1'b1);
        ctl(1'b0, 3'h4, 3'h2);
        switchEnableConfigBit <= 1'b0;
    endtask
    task scenPll;
        setNext(3'h3);
        pllLocked <= 1'b0;
        clockFailEvent <= 1'b1;
        @(posedge sys_clk);
        clockFailEvent <= 1'b0;
        rdw(12'h000);
        check({31'h0, rd[3]}, 32'h1);
        req(1'b1);
        repeat (10) @(posedge sys_clk);
        rdw(12'h000);
        check({26'h0, rd[5], 1'b0, rd[3], 2'h0, rd[0]}, 32'h1);
        check({31'h0, pllEnable}, 32'h1);
        req(1'b0);
        repeat (4) @(posedge sys_clk);
        ctl(1'b0, 3'h3, 3'h2);
        check({31'h0, pllEnable}, 32'h0);
        req(1'b1);
        pllLocked <= 1'b1;
        waitCur(3'h3);
        ctl(1'b0, 3'h3, 3'h3);
        watchdogEnable <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({31'h0, sourcePowerOn[5]}, 32'h1);
        watchdogEnable <= 1'b0;
    endtask
    task scenSleep;
        sourceRunning <= 1'b0;
        setNext(3'h4);
        req(1'b1);
        sleepEnter <= 1'b1;
        @(posedge sys_clk);
        sleepEnter <= 1'b0;
        repeat (2) @(posedge sys_clk);
        ctl(1'b0, 3'h4, 3'h3);
        check({29'h0, selectedSource}, 32'h3);
    endtask
    task scenTwoSpeed;
        rst <= 1'b1;
        twoSpeedStartupEnable <= 1'b1;
        startupSourceConfig <= 3'h2;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rdw(12'h000);
        check({26'h0, rd[14:12], rd[10:8]}, {26'h0, 3'h0, 3'h2});
        sourceRunning <= 1'b1;
        waitCur(3'h2);
        check({29'h0, selectedSource}, 32'h2);
        sleepWake <= 1'b1;
        @(posedge sys_clk);
        sleepWake <= 1'b0;
        rdw(12'h000);
        check({26'h0, rd[14:12], rd[10:8]}, {26'h0, 3'h0, 3'h2});
        waitCur(3'h2);
        check({29'h0, selectedSource}, 32'h2);
    endtask
    initial
    begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        startupSourceConfig = 3'h0;
        {switchEnableConfigBit, twoSpeedStartupEnable, failSafeMonitorEnable} = 3'h0;
        {watchdogEnable, secondaryOscEnable, pllLocked, sourceRunning} = 4'h0;
        {sleepEnter, sleepWake, clockFailEvent} = 3'h0;
        n_fail = 0;
        comparisons = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        scenReset();
        scenPrimary();
        scenRedundant();
        scenKeys();
        scenPll();
        scenSleep();
        scenTwoSpeed();
        summarize();
    end
    // Whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end
endmodule
